// ### rsm_reset_source_manager.sv
// reset source manager: gathers reset requests, sequences release, keeps cause flags
// Summary of operation
// - manager always on, pin source needs enabling
// - record reset cause in cause flags
// - flags hold until written one
// - bits5..0: debug, soft, wdog, pin, brown, power
// - power-up clears all but power flag
// - after power-up, others wait full boot
// - soft request bit triggers immediate reset
// - soft request bit reads zero
// - unprotected protected-write changes nothing
// - pin low holds reset when enabled
// - power-up resets all, brown-out spares config
// - user resets spare debug and brown config
// - fuse registers reloaded after release
// - init lengthened by start-up and crc
// - watchdog timeout issues watchdog reset
// - debug reset reachable only by debugger
// - operates in active and sleep modes
module rsm_reset_source_manager #(
	parameter int          CAUSE_W   = rsm_pkg::RSM_NUM_CAUSE,   // number of cause flags
	parameter logic [11:0] INIT_BASE = rsm_pkg::RSM_INIT_BASE    // base init cycles
) (
	input  wire logic        clk,
	input  wire logic        rst_b,            // power-up reset from the supply detector
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	// reset requesters
	input  wire logic        brownout_req,     // brown-out detector request, async level
	input  wire logic        reset_pin_b,      // external reset pin, active low
	input  wire logic        pin_reset_en,     // fuse: external reset enabled
	input  wire logic        watchdog_timeout, // watchdog expired unserviced, async level
	input  wire logic        debug_port_req,   // debugger reset request, async level
	// start-up configuration
	input  wire logic [2:0]  startup_delay_fuse,
	input  wire logic        boot_crc_scan_select,
	// reset outputs
	output logic             sys_rst_b,        // core logic reset, low while held
	output logic             debug_rst_b,      // debug port reset, only on power-up
	output logic             brownout_cfg_rst_b, // brown-out configuration reset
	output logic             fuse_reload       // one-cycle pulse: reload fuse registers
);
	// all state of this block
	typedef struct packed {
		logic [5:0]                 cause;     // sticky cause flags
		logic                       boot_done; // a full boot has completed since power-up
		logic                       soft_req;  // latched software reset request
		rsm_pkg::rsm_state_e        state;     // release sequencer
		logic [11:0]                cnt;       // init countdown
		logic [1:0]                 brn_sync;  // brown-out synchroniser
		logic [1:0]                 pin_sync;  // pin synchroniser, resets to the idle high level
		logic [1:0]                 wdg_sync;  // watchdog synchroniser
		logic [1:0]                 dbg_sync;  // debug synchroniser
		logic [7:0]                 rdata;     // read data
		logic                       reload;    // fuse reload pulse
	} rsm_top_s;

	rsm_top_s s_q;
	rsm_top_s s_d;

	logic       win_open;  // protection window open
	logic       key_hit;   // key write seen
	logic       sw_wr;     // write to soft reset register
	logic       any_user;  // any user reset request
	logic       brn_req;   // synchronised brown-out
	logic       pin_req;   // synchronised, enabled pin request
	logic       wdg_req;   // synchronised watchdog request
	logic       dbg_req;   // synchronised debug request
	logic [5:0] hw_set;    // flags to set this cycle
	logic [5:0] w1c;       // flags written one

	rsm_unlock u_unlock (
		.clk         (clk),
		.rst_b       (rst_b),
		.key_hit     (key_hit),
		.consume     (sw_wr),
		.open_window (win_open)
	);

	// decode helper for writes
	function automatic logic rsm_wr_at(input logic [7:0] a, input logic [7:0] ofs, input logic wr);
		rsm_wr_at = wr && (a == ofs);
	endfunction

	assign key_hit = rsm_wr_at(reg_addr, rsm_pkg::RSM_OFS_PROTECT, reg_wr)
		&& (reg_wdata == rsm_pkg::RSM_IO_PROTECT_KEY);
	assign sw_wr   = rsm_wr_at(reg_addr, rsm_pkg::RSM_OFS_SWRST, reg_wr);

	// synchronised requesters, second flop only
	// pin low holds reset when fuse enables it
	assign pin_req = pin_reset_en && !s_q.pin_sync[1];
	// watchdog timeout is a reset source
	assign wdg_req = s_q.wdg_sync[1];
	// debug request only from the debug port input
	assign dbg_req = s_q.dbg_sync[1];
	assign brn_req = s_q.brn_sync[1];
	assign any_user = pin_req || wdg_req || dbg_req || s_q.soft_req;

	// every active requester sets its own flag
	always_comb begin
		hw_set = '0;
		hw_set[rsm_pkg::RSM_BIT_BROWN] = brn_req;
		hw_set[rsm_pkg::RSM_BIT_PIN]   = pin_req;
		hw_set[rsm_pkg::RSM_BIT_WDOG]  = wdg_req;
		hw_set[rsm_pkg::RSM_BIT_SOFT]  = s_q.soft_req;
		hw_set[rsm_pkg::RSM_BIT_DEBUG] = dbg_req;
	end

	assign w1c = rsm_wr_at(reg_addr, rsm_pkg::RSM_OFS_CAUSE, reg_wr) ? reg_wdata[5:0] : 6'h00;

	// next state
	always_comb begin
		s_d = s_q;
		s_d.reload = 1'b0;
		// two-flop synchronisers
		s_d.brn_sync = {s_q.brn_sync[0], brownout_req};
		s_d.pin_sync = {s_q.pin_sync[0], reset_pin_b};
		s_d.wdg_sync = {s_q.wdg_sync[0], watchdog_timeout};
		s_d.dbg_sync = {s_q.dbg_sync[0], debug_port_req};

		// hardware set wins over a clear in the same cycle
		// only power flag until a full boot
		if (s_q.boot_done) begin
			s_d.cause = (s_q.cause & ~w1c) | hw_set;
		end else begin
			s_d.cause = s_q.cause & ~w1c;
		end

		// protected write of request bit starts reset at once
		// writes outside the window change nothing
		if (sw_wr && win_open && reg_wdata[rsm_pkg::RSM_BIT_SWREQ]) begin
			s_d.soft_req = 1'b1;
		end

		// no sleep input gates this block
		unique case (s_q.state)
			rsm_pkg::RSM_ST_HOLD: begin
				// hold while any request stays active
				if (!any_user && !brn_req) begin
					s_d.state = rsm_pkg::RSM_ST_INIT;
					// init lengthened by start-up delay and crc scan
					s_d.cnt = INIT_BASE
						+ ({9'h000, startup_delay_fuse} << rsm_pkg::RSM_SUT_SHIFT)
						+ (boot_crc_scan_select ? rsm_pkg::RSM_CRC_EXTRA : 12'h000);
				end
				// soft request lasts one hold pass
				s_d.soft_req = 1'b0;
			end
			rsm_pkg::RSM_ST_INIT: begin
				if (any_user || brn_req) begin
					s_d.state = rsm_pkg::RSM_ST_HOLD;
				end else if (s_q.cnt == 12'h000) begin
					s_d.state = rsm_pkg::RSM_ST_RUN;
					s_d.boot_done = 1'b1;
					s_d.reload = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt - 12'h001;
				end
			end
			rsm_pkg::RSM_ST_RUN: begin
				if (any_user || brn_req) begin
					s_d.state = rsm_pkg::RSM_ST_HOLD;
				end
			end
		endcase

		// read path, data stand one cycle later
		s_d.rdata = 8'h00;
		if (reg_rd && reg_addr == rsm_pkg::RSM_OFS_CAUSE) begin
			s_d.rdata = {2'b00, s_q.cause};
		end
		// soft request register always reads zero, unmapped reads zero
	end

	// state register; power-up takes every field to its reset value
	// power-up leaves only the power flag set
	// power-up resets all volatile state here
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q           <= '0;
			s_q.cause     <= rsm_pkg::RSM_CAUSE_RST;
			s_q.state     <= rsm_pkg::RSM_ST_HOLD;
			s_q.pin_sync  <= 2'b11;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata          = s_q.rdata;
	// user resets hold core only, not debug or brown config
	assign sys_rst_b          = (s_q.state == rsm_pkg::RSM_ST_RUN);
	assign debug_rst_b        = rst_b;
	assign brownout_cfg_rst_b = rst_b;
	assign fuse_reload        = s_q.reload;
endmodule // rsm_reset_source_manager

// ### rsm_pkg.sv
// reset source manager package: offsets, field positions, reset values, counts
package rsm_pkg;
	// register offsets (byte addresses on the plain register port)
	localparam logic [7:0] RSM_OFS_CAUSE   = 8'h00;
	localparam logic [7:0] RSM_OFS_SWRST   = 8'h01;
	localparam logic [7:0] RSM_OFS_PROTECT = 8'h02;
	// cause flag positions
	localparam int RSM_BIT_PWRUP   = 0;
	localparam int RSM_BIT_BROWN   = 1;
	localparam int RSM_BIT_PIN     = 2;
	localparam int RSM_BIT_WDOG    = 3;
	localparam int RSM_BIT_SOFT    = 4;
	localparam int RSM_BIT_DEBUG   = 5;
	localparam int RSM_NUM_CAUSE   = 6;
	// software reset request bit position
	localparam int RSM_BIT_SWREQ   = 0;
	// io protection key value
	localparam logic [7:0] RSM_IO_PROTECT_KEY = 8'hd8;
	// unlock window length in clock cycles (four instructions)
	localparam logic [2:0] RSM_UNLOCK_CYCLES  = 3'h4;
	// reset values
	localparam logic [5:0] RSM_CAUSE_RST      = 6'h01;
	localparam logic [7:0] RSM_SWRST_RST      = 8'h00;
	// base internal initialization length, cycles
	localparam logic [11:0] RSM_INIT_BASE     = 12'h010;
	// extra cycles for boot crc scan
	localparam logic [11:0] RSM_CRC_EXTRA     = 12'h100;
	// shift for extra cycles per start-up delay fuse step (16 cycles per step)
	localparam int RSM_SUT_SHIFT              = 4;
	// sequencer states
	typedef enum logic [1:0] {
		RSM_ST_HOLD,
		RSM_ST_INIT,
		RSM_ST_RUN
	} rsm_state_e;
endpackage : rsm_pkg

// ### rsm_unlock.sv
// protection unlock window: key write opens a short window for protected writes
module rsm_unlock #(
	parameter logic [2:0] WINDOW = rsm_pkg::RSM_UNLOCK_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       key_hit,     // key written to protection register
	input  wire logic       consume,     // protected write used the window
	output logic            open_window  // protected writes allowed
);
	typedef struct packed {
		logic [2:0] cnt; // remaining window cycles
	} rsm_unlock_s;

	rsm_unlock_s s_q;
	rsm_unlock_s s_d;

	// window count: reload on key, drop on use, else count down
	always_comb begin
		s_d = s_q;
		if (key_hit) begin
			s_d.cnt = WINDOW;
		end else if (consume) begin
			s_d.cnt = 3'h0;
		end else if (s_q.cnt != 3'h0) begin
			s_d.cnt = s_q.cnt - 3'h1;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign open_window = (s_q.cnt != 3'h0);
endmodule // rsm_unlock

// ### rsm_properties.sv
// port checker for the reset source manager, bound to its top module
module rsm_checker (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       reset_pin_b,
	input wire logic       pin_reset_en,
	input wire logic       watchdog_timeout,
	input wire logic       debug_port_req,
	input wire logic       brownout_req,
	input wire logic       sys_rst_b,
	input wire logic       debug_rst_b,
	input wire logic       brownout_cfg_rst_b,
	input wire logic       fuse_reload
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [5:0] key_q; // recent key writes, wider than the window for margin
	logic       key_w; // key written to the protection register
	logic       sw_w;  // soft request bit written
	assign key_w = reg_wr && reg_addr == rsm_pkg::RSM_OFS_PROTECT && reg_wdata == rsm_pkg::RSM_IO_PROTECT_KEY;
	assign sw_w = reg_wr && reg_addr == rsm_pkg::RSM_OFS_SWRST && reg_wdata[0];
	// key history, so a locked write can be told apart
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) key_q <= 6'h00;
		else key_q <= {key_q[4:0], key_w};
	end
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle zero");
	chk_swreq_zero: assert property (reg_rd && reg_addr == rsm_pkg::RSM_OFS_SWRST |=> reg_rdata == 8'h00)
		else $error("soft trigger read not zero");
	chk_cause_high: assert property (reg_rd && reg_addr == rsm_pkg::RSM_OFS_CAUSE |=> reg_rdata[7:6] == 2'h0)
		else $error("cause high bits set");
	chk_soft_trig: assert property (key_w && sys_rst_b ##[1:3] sw_w |-> ##[1:3] !sys_rst_b)
		else $error("unlocked soft reset not taken");
	chk_soft_locked: assert property (sw_w && key_q == 6'h00 && !key_w && sys_rst_b |=> sys_rst_b[*4])
		else $error("locked soft write took effect");
	chk_pin_hold: assert property ((pin_reset_en && !reset_pin_b)[*5] |-> !sys_rst_b)
		else $error("pin low but not in reset");
	chk_wdog_hold: assert property (watchdog_timeout[*5] |-> !sys_rst_b)
		else $error("watchdog request ignored");
	chk_other_hold: assert property ((debug_port_req || brownout_req)[*5] |-> !sys_rst_b)
		else $error("debug or brown-out request ignored");
	chk_spare_rst: assert property (!sys_rst_b |-> debug_rst_b && brownout_cfg_rst_b)
		else $error("user reset reached spared logic");
	chk_fuse_pulse: assert property (fuse_reload |=> !fuse_reload)
		else $error("fuse reload longer than a cycle");
	chk_fuse_rel: assert property (fuse_reload |-> ##[0:1] sys_rst_b)
		else $error("fuse reload while still held");
	cov_soft: cover property (key_w ##[1:3] sw_w);
	cov_pin: cover property ((pin_reset_en && !reset_pin_b)[*5]);
	cov_fuse: cover property (fuse_reload);
endmodule // rsm_checker
bind rsm_reset_source_manager rsm_checker u_chk (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .reset_pin_b, .pin_reset_en, .watchdog_timeout, .debug_port_req, .brownout_req,
	.sys_rst_b, .debug_rst_b, .brownout_cfg_rst_b, .fuse_reload);

// ### rsm_far_side.sv
// far side model: supply monitor, watchdog, debugger and reset pin
module rsm_far_side (
	input  wire logic       clk,
	input  wire logic [3:0] ask,              // brown, pin, watchdog, debug
	output logic            brownout_req,
	output logic            reset_pin_b,
	output logic            watchdog_timeout,
	output logic            debug_port_req
);
	timeunit 1ns;
	timeprecision 1ns;
	// all quiet at time zero, pin idles high
	initial begin
		brownout_req = 1'b0;
		reset_pin_b = 1'b1;
		watchdog_timeout = 1'b0;
		debug_port_req = 1'b0;
	end
	// levels move just after the edge and stand while asked
	always @(posedge clk) begin
		brownout_req <= ask[0];
		reset_pin_b <= !ask[1];
		watchdog_timeout <= ask[2];
		debug_port_req <= ask[3];
	end
endmodule // rsm_far_side

// ### tb_reset_source_manager.sv
// self-checking bench for the reset source manager
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_reset_source_manager;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] CA = rsm_pkg::RSM_OFS_CAUSE;
	logic       clk, rst_b, reg_wr, reg_rd, pin_reset_en, boot_crc_scan_select, fuse_reload, seen;
	logic       brownout_req, reset_pin_b, watchdog_timeout, debug_port_req, sys_rst_b;
	logic       debug_rst_b, brownout_cfg_rst_b; // spared resets, follow power-up only
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [2:0] startup_delay_fuse;
	logic [3:0] ask;
	int         n_fail, samples_checked, cyc, i;
	logic [7:0] flag_tab [4] = '{8'h02, 8'h04, 8'h08, 8'h20}; // cause bit per requester
	// short base init keeps boots quick
	rsm_reset_source_manager #(.INIT_BASE(12'h004)) DUT (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .brownout_req, .reset_pin_b, .pin_reset_en, .watchdog_timeout, .debug_port_req,
		.startup_delay_fuse, .boot_crc_scan_select, .sys_rst_b, .debug_rst_b, .brownout_cfg_rst_b,
		.fuse_reload);
	rsm_far_side u_far (.clk, .ask, .brownout_req, .reset_pin_b, .watchdog_timeout, .debug_port_req);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// hang guard, far above the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			n_fail++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic waitn(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// bounded wait for release, noting the reload pulse
	task automatic boot();
		seen = 1'b0;
		for (int n = 0; n < 1000 && sys_rst_b !== 1'b1; n++) begin
			waitn(1);
			seen |= fuse_reload;
		end
		waitn(1);
		seen |= fuse_reload;
		`CHK("sys_rst_b", 1'b1, sys_rst_b)
		`CHK("fuse_reload", 1'b1, seen)
	endtask
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		ask = 4'h0;
		pin_reset_en = 1'b1;
		startup_delay_fuse = 3'h2;
		boot_crc_scan_select = 1'b0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		boot();
		rd(CA, d);
		`CHK("cause after power-up", 8'h01, d)
		wr(CA, 8'h01);
		rd(CA, d);
		`CHK("cause cleared", 8'h00, d)
		rd(rsm_pkg::RSM_OFS_SWRST, d);
		`CHK("soft trigger read", 8'h00, d)
		rd(8'h05, d);
		`CHK("unmapped read", 8'h00, d)
		wr(rsm_pkg::RSM_OFS_SWRST, 8'h01);
		waitn(8);
		`CHK("locked soft write", 1'b1, sys_rst_b)
		wr(rsm_pkg::RSM_OFS_PROTECT, rsm_pkg::RSM_IO_PROTECT_KEY);
		wr(rsm_pkg::RSM_OFS_SWRST, 8'h01);
		waitn(3);
		`CHK("soft reset taken", 1'b0, sys_rst_b)
		`CHK("debug spared", 1'b1, debug_rst_b)
		`CHK("brown cfg spared", 1'b1, brownout_cfg_rst_b)
		boot();
		rd(CA, d);
		`CHK("soft cause", 8'h10, d)
		pin_reset_en <= 1'b0;
		ask <= 4'h2;
		waitn(10);
		`CHK("pin disabled", 1'b1, sys_rst_b)
		ask <= 4'h0;
		// let the high pin level pass the far side and both sync flops first
		waitn(5);
		pin_reset_en <= 1'b1;
		// each requester alone, then two at once
		for (i = 0; i < 5; i++) begin
			wr(CA, 8'h3f);
			ask <= (i < 4) ? 4'(1 << i) : 4'hc;
			waitn(10);
			`CHK("held in reset", 1'b0, sys_rst_b)
			ask <= 4'h0;
			boot();
			rd(CA, d);
			`CHK("requester cause", (i < 4) ? flag_tab[i] : 8'h28, d)
		end
		rst_b <= 1'b0;
		waitn(3);
		`CHK("debug reset on power-up", 1'b0, debug_rst_b)
		`CHK("brown cfg reset on power-up", 1'b0, brownout_cfg_rst_b)
		rst_b <= 1'b1;
		boot();
		rd(CA, d);
		`CHK("cause after second power-up", 8'h01, d)
		end_sim();
	end
endmodule // tb_reset_source_manager
